// File: core/bmcsr_pkg.sv
// Package: register map, reset values and encodings of the bus management CSR unit
package bmcsr_pkg;

  // Host register offsets (byte addresses)
  localparam logic [7:0]  OFS_SWAP_DATA    = 8'h00;
  localparam logic [7:0]  OFS_COMPARE      = 8'h04;
  localparam logic [7:0]  OFS_CAS_CONTROL  = 8'h08;
  localparam logic [7:0]  OFS_ROM_HEADER   = 8'h0C;
  localparam logic [7:0]  OFS_BUS_IDENT    = 8'h10;
  localparam logic [7:0]  OFS_RESOURCE0    = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h24;
  localparam logic [7:0]  OFS_IRQ_MASK     = 8'h28;

  // Serial-bus CSR addresses
  localparam logic [47:0] CSR_RESOURCE_BASE = 48'hFFFF_F000_021C;
  localparam logic [47:0] CSR_RESOURCE_LAST = 48'hFFFF_F000_0228;
  localparam logic [47:0] CSR_ROM_HEADER    = 48'hFFFF_F000_0400;
  localparam logic [47:0] CSR_BUS_INFO0     = 48'hFFFF_F000_0404;

  // Resource selectors
  localparam logic [1:0]  SEL_BUS_MANAGER  = 2'h0;
  localparam logic [1:0]  SEL_BANDWIDTH    = 2'h1;
  localparam logic [1:0]  SEL_CHAN_HI      = 2'h2;
  localparam logic [1:0]  SEL_CHAN_LO      = 2'h3;

  // Reset values
  localparam logic [31:0] RST_BUS_MANAGER  = 32'h0000_003F;
  localparam logic [31:0] RST_BANDWIDTH    = 32'h0000_1333;
  localparam logic [31:0] RST_CHANNELS     = 32'hFFFF_FFFF;
  localparam logic [7:0]  RST_INFO_LENGTH  = 8'h04;
  localparam logic [7:0]  RST_CRC_LENGTH   = 8'h04;
  localparam logic [15:0] RST_ROM_CRC      = 16'h0000;
  localparam logic [31:0] BUS_IDENT_VALUE  = 32'h3133_3934;

  // Field positions
  localparam int          POS_CAS_DONE     = 31;
  localparam int          POS_INFO_LENGTH  = 24;
  localparam int          POS_CRC_LENGTH   = 16;
  localparam int          POS_IRQ_HOST     = 0;
  localparam int          POS_IRQ_BUS      = 1;

  // Resource width masks
  localparam logic [31:0] MASK_BUS_MANAGER = 32'h0000_003F;
  localparam logic [31:0] MASK_BANDWIDTH   = 32'h0000_1FFF;

  typedef enum logic [1:0] {
    BMCSR_IDLE    = 2'b00,
    BMCSR_HOST_OP = 2'b01,
    BMCSR_BUS_OP  = 2'b10
  } bmcsr_state_t;

endpackage : bmcsr_pkg

// File: core/bmcsr_unit.sv
// Bus management CSR unit: compare-and-swap resources, config ROM header, bus identification
module bmcsr_unit
  import bmcsr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_bus_reset,
  // ID ROM
  input  wire logic        i_id_rom_present,
  input  wire logic [15:0] i_id_rom_crc,
  // Host register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata,
  // Serial-bus request side
  input  wire logic        i_bus_req,
  input  wire logic        i_bus_lock,
  input  wire logic [47:0] i_bus_addr,
  input  wire logic [31:0] i_bus_arg,
  input  wire logic [31:0] i_bus_data,
  output logic             o_bus_ack,
  output logic             o_bus_err,
  output logic [31:0]      o_bus_rdata,
  // Interrupt
  output logic             o_irq
);

  bmcsr_state_t state_ff;
  logic [31:0]  res_ff [4];
  logic [31:0]  swap_data_ff;
  logic [31:0]  compare_ff;
  logic [1:0]   sel_ff;
  logic         done_ff;
  logic [7:0]   info_len_ff;
  logic [7:0]   crc_len_ff;
  logic [15:0]  rom_crc_ff;
  logic         rom_load_ff;
  logic [31:0]  reg_rdata_ff;
  logic         bus_ack_ff;
  logic         bus_err_ff;
  logic [31:0]  bus_rdata_ff;
  logic [1:0]   irq_status_ff;
  logic [1:0]   irq_mask_ff;
  logic         irq_ff;
  logic         bus_pend_ff;
  logic         bus_lock_ff;
  logic [47:0]  bus_addr_ff;
  logic [31:0]  bus_arg_ff;
  logic [31:0]  bus_data_ff;

  // Width mask of a resource
  function automatic logic [31:0] res_mask(input logic [1:0] sel);
    if (sel == SEL_BUS_MANAGER) begin
      return MASK_BUS_MANAGER;
    end else if (sel == SEL_BANDWIDTH) begin
      return MASK_BANDWIDTH;
    end else begin
      return RST_CHANNELS;
    end
  endfunction : res_mask

  // Resource hit for a bus address
  function automatic logic res_hit(input logic [47:0] addr);
    return (addr >= CSR_RESOURCE_BASE) && (addr <= CSR_RESOURCE_LAST) && (addr[1:0] == 2'h0);
  endfunction : res_hit

  logic [1:0]  bus_sel;
  logic [1:0]  op_sel;
  logic [31:0] op_old;
  logic [31:0] op_cmp;
  logic [31:0] op_new;
  logic        op_swap;
  logic        ctl_wr;
  logic        host_evt;
  logic        bus_evt;

  // Quadlet index 21C..228 maps to selector 0..3
  assign bus_sel  = bus_addr_ff[3:2] + 2'h1;
  assign ctl_wr   = i_reg_wr && (i_reg_addr == OFS_CAS_CONTROL);
  assign op_sel   = (state_ff == BMCSR_BUS_OP) ? bus_sel : sel_ff;
  assign op_old   = res_ff[op_sel];
  assign op_cmp   = (state_ff == BMCSR_BUS_OP) ? bus_arg_ff : compare_ff;
  assign op_new   = (state_ff == BMCSR_BUS_OP) ? bus_data_ff : swap_data_ff;
  assign op_swap  = (op_old == (op_cmp & res_mask(op_sel)));
  assign host_evt = (state_ff == BMCSR_HOST_OP);
  assign bus_evt  = (state_ff == BMCSR_BUS_OP);

  // Bus request capture, held until served
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      bus_pend_ff <= 1'b0;
      bus_lock_ff <= 1'b0;
      bus_addr_ff <= 48'h0;
      bus_arg_ff  <= 32'h0;
      bus_data_ff <= 32'h0;
    end else if (i_bus_req && !bus_pend_ff) begin
      bus_pend_ff <= 1'b1;
      bus_lock_ff <= i_bus_lock;
      bus_addr_ff <= i_bus_addr;
      bus_arg_ff  <= i_bus_arg;
      bus_data_ff <= i_bus_data;
    end else if (state_ff == BMCSR_BUS_OP) begin
      bus_pend_ff <= 1'b0;
    end
  end

  // Arbiter: one operation at a time, bus first
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_ff <= BMCSR_IDLE;
    end else begin
      case (state_ff)
        BMCSR_IDLE: begin
          if (bus_pend_ff) begin
            state_ff <= BMCSR_BUS_OP;
          end else if (!done_ff) begin
            state_ff <= BMCSR_HOST_OP;
          end
        end
        default: begin
          state_ff <= BMCSR_IDLE;
        end
      endcase
    end
  end

  // Resources, written only by compare-and-swap
  generate
    for (genvar g = 0; g < 4; g++) begin : g_res
      always_ff @(posedge i_clock) begin
        if (i_srst || i_bus_reset) begin
          res_ff[g] <= (g == 0) ? RST_BUS_MANAGER : (g == 1) ? RST_BANDWIDTH : RST_CHANNELS;
        end else if (op_sel == 2'(g) && op_swap && (host_evt || (bus_evt && bus_lock_ff && res_hit(bus_addr_ff)))) begin
          res_ff[g] <= op_new & res_mask(2'(g));
        end
      end
    end
  endgenerate

  // Host compare-and-swap registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      swap_data_ff <= 32'h0;
      compare_ff   <= 32'h0;
      sel_ff       <= SEL_BUS_MANAGER;
      done_ff      <= 1'b1;
    end else begin
      if (host_evt) begin
        swap_data_ff <= op_old;
        done_ff      <= 1'b1;
      end else if (i_reg_wr && i_reg_addr == OFS_SWAP_DATA && done_ff) begin
        swap_data_ff <= i_reg_wdata;
      end
      if (i_reg_wr && i_reg_addr == OFS_COMPARE) begin
        compare_ff <= i_reg_wdata;
      end
      if (ctl_wr) begin
        sel_ff  <= i_reg_wdata[1:0];
        done_ff <= 1'b0;
      end
    end
  end

  // Config ROM header, CRC loaded after reset release
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      info_len_ff <= RST_INFO_LENGTH;
      crc_len_ff  <= RST_CRC_LENGTH;
      rom_crc_ff  <= RST_ROM_CRC;
      rom_load_ff <= 1'b1;
    end else begin
      rom_load_ff <= 1'b0;
      if (rom_load_ff && i_id_rom_present) begin
        rom_crc_ff <= i_id_rom_crc;
      end else if (i_reg_wr && i_reg_addr == OFS_ROM_HEADER) begin
        info_len_ff <= i_reg_wdata[31:24];
        crc_len_ff  <= i_reg_wdata[23:16];
        rom_crc_ff  <= i_reg_wdata[15:0];
      end
    end
  end

  // Interrupt status, set wins over clear
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_status_ff <= 2'h0;
      irq_mask_ff   <= 2'h0;
      irq_ff        <= 1'b0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~((i_reg_wr && i_reg_addr == OFS_IRQ_STATUS) ? i_reg_wdata[1:0] : 2'h0))
                       | {bus_evt, host_evt};
      if (i_reg_wr && i_reg_addr == OFS_IRQ_MASK) begin
        irq_mask_ff <= i_reg_wdata[1:0];
      end
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // Host read data
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      reg_rdata_ff <= 32'h0;
    end else if (i_reg_rd) begin
      if (i_reg_addr == OFS_SWAP_DATA) begin
        reg_rdata_ff <= swap_data_ff;
      end else if (i_reg_addr == OFS_COMPARE) begin
        reg_rdata_ff <= compare_ff;
      end else if (i_reg_addr == OFS_CAS_CONTROL) begin
        reg_rdata_ff <= {done_ff, 29'h0, sel_ff};
      end else if (i_reg_addr == OFS_ROM_HEADER) begin
        reg_rdata_ff <= {info_len_ff, crc_len_ff, rom_crc_ff};
      end else if (i_reg_addr == OFS_BUS_IDENT) begin
        reg_rdata_ff <= BUS_IDENT_VALUE;
      end else if (i_reg_addr >= OFS_RESOURCE0 && i_reg_addr < OFS_IRQ_STATUS) begin
        reg_rdata_ff <= res_ff[i_reg_addr[3:2] + 2'h3];
      end else if (i_reg_addr == OFS_IRQ_STATUS) begin
        reg_rdata_ff <= {30'h0, irq_status_ff};
      end else if (i_reg_addr == OFS_IRQ_MASK) begin
        reg_rdata_ff <= {30'h0, irq_mask_ff};
      end else begin
        reg_rdata_ff <= 32'h0;
      end
    end else begin
      reg_rdata_ff <= 32'h0;
    end
  end

  // Serial-bus answers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      bus_ack_ff   <= 1'b0;
      bus_err_ff   <= 1'b0;
      bus_rdata_ff <= 32'h0;
    end else begin
      bus_ack_ff <= bus_evt;
      bus_err_ff <= 1'b0;
      if (bus_evt) begin
        if (res_hit(bus_addr_ff)) begin
          bus_rdata_ff <= op_old;
        end else if (!bus_lock_ff && bus_addr_ff == CSR_ROM_HEADER) begin
          bus_rdata_ff <= {info_len_ff, crc_len_ff, rom_crc_ff};
        end else if (!bus_lock_ff && bus_addr_ff == CSR_BUS_INFO0) begin
          bus_rdata_ff <= BUS_IDENT_VALUE;
        end else begin
          bus_rdata_ff <= 32'h0;
          bus_err_ff   <= 1'b1;
        end
      end
    end
  end

  assign o_reg_rdata = reg_rdata_ff;
  assign o_bus_ack   = bus_ack_ff;
  assign o_bus_err   = bus_err_ff;
  assign o_bus_rdata = bus_rdata_ff;
  assign o_irq       = irq_ff;

  AST_DONE_CLEAR: assert property (@(posedge i_clock) disable iff (i_srst) ctl_wr |=> !done_ff)
    else $error("done flag not cleared by control write");
  AST_DONE_SET: assert property (@(posedge i_clock) disable iff (i_srst) ctl_wr |=> ##[1:4] done_ff)
    else $error("host operation did not finish");
  AST_OLD_VALUE: assert property (@(posedge i_clock) disable iff (i_srst) host_evt |=> swap_data_ff == $past(op_old))
    else $error("swap data lacks old value");
  AST_NO_SWAP: assert property (@(posedge i_clock) disable iff (i_srst || i_bus_reset)
      host_evt && !op_swap |=> res_ff[$past(op_sel)] == $past(op_old))
    else $error("resource changed on mismatch");
  AST_SWAP: assert property (@(posedge i_clock) disable iff (i_srst || i_bus_reset)
      host_evt && op_swap |=> res_ff[$past(op_sel)] == ($past(op_new) & res_mask($past(op_sel))))
    else $error("resource not swapped");
  AST_BUS_ANSWER: assert property (@(posedge i_clock) disable iff (i_srst) i_bus_req && !bus_pend_ff |-> ##[2:4] o_bus_ack)
    else $error("bus request not answered");
  AST_ONE_OP: assert property (@(posedge i_clock) disable iff (i_srst) host_evt |-> !bus_evt)
    else $error("operations interleaved");
  AST_BUS_FIRST: assert property (@(posedge i_clock) disable iff (i_srst)
      state_ff == BMCSR_IDLE && bus_pend_ff |=> bus_evt)
    else $error("bus request not served first");
  AST_RESET_VAL: assert property (@(posedge i_clock) $past(i_bus_reset) && !$past(i_srst) |->
      res_ff[1] == RST_BANDWIDTH && res_ff[0] == RST_BUS_MANAGER)
    else $error("bus reset values wrong");
  AST_IDENT: assert property (@(posedge i_clock) disable iff (i_srst)
      i_reg_rd && i_reg_addr == OFS_BUS_IDENT |=> o_reg_rdata == 32'h3133_3934)
    else $error("bus identification wrong");

  // Serial-bus answers, resource updates and config ROM header
  AST_ACK_PULSE: assert property (@(posedge i_clock) disable iff (i_srst)
      o_bus_ack |=> !o_bus_ack)
    else $error("bus answer longer than one cycle");

  AST_ACK_ONLY_OP: assert property (@(posedge i_clock) disable iff (i_srst)
      o_bus_ack |-> $past(bus_evt))
    else $error("bus answer without operation");

  AST_ERR_WITH_ACK: assert property (@(posedge i_clock) disable iff (i_srst)
      o_bus_err |-> o_bus_ack)
    else $error("bus error without answer");

  AST_LOCK_ROM_ERR: assert property (@(posedge i_clock) disable iff (i_srst)
      bus_evt && bus_lock_ff && !res_hit(bus_addr_ff) |=> o_bus_err)
    else $error("lock outside resources not refused");

  AST_ROM_READ: assert property (@(posedge i_clock) disable iff (i_srst)
      bus_evt && !bus_lock_ff && bus_addr_ff == CSR_ROM_HEADER |=> o_bus_rdata == $past({info_len_ff, crc_len_ff, rom_crc_ff}))
    else $error("bus read of header wrong");

  AST_INFO_BLOCK: assert property (@(posedge i_clock) disable iff (i_srst)
      bus_evt && !bus_lock_ff && bus_addr_ff == CSR_BUS_INFO0 |=> o_bus_rdata == BUS_IDENT_VALUE)
    else $error("bus read of info block wrong");

  AST_BUS_OLD: assert property (@(posedge i_clock) disable iff (i_srst)
      bus_evt && res_hit(bus_addr_ff) |=> o_bus_rdata == $past(op_old))
    else $error("bus answer lacks old resource value");

  AST_BUS_READ_KEEPS: assert property (@(posedge i_clock) disable iff (i_srst)
      bus_evt && !bus_lock_ff && !i_bus_reset |=> res_ff[$past(op_sel)] == $past(op_old))
    else $error("bus read changed a resource");

  AST_BUS_SWAP: assert property (@(posedge i_clock) disable iff (i_srst)
      bus_evt && bus_lock_ff && res_hit(bus_addr_ff) && op_swap && !i_bus_reset
      |=> res_ff[$past(op_sel)] == ($past(op_new) & res_mask($past(op_sel))))
    else $error("bus lock did not swap");

  AST_BUS_NOSWAP: assert property (@(posedge i_clock) disable iff (i_srst)
      bus_evt && !op_swap && !i_bus_reset |=> res_ff[$past(op_sel)] == $past(op_old))
    else $error("bus lock swapped on mismatch");

  AST_NO_PLAIN_WRITE: assert property (@(posedge i_clock) disable iff (i_srst)
      state_ff == BMCSR_IDLE && !i_bus_reset |=> $stable({res_ff[0], res_ff[1], res_ff[2], res_ff[3]}))
    else $error("resource changed outside compare-and-swap");

  AST_BUS_RESET: assert property (@(posedge i_clock) disable iff (i_srst)
      i_bus_reset |=> res_ff[2] == RST_CHANNELS && res_ff[3] == RST_CHANNELS)
    else $error("channel resources not reset");

  AST_HEADER_KEPT: assert property (@(posedge i_clock) disable iff (i_srst)
      i_bus_reset && !rom_load_ff && !(i_reg_wr && i_reg_addr == OFS_ROM_HEADER)
      |=> $stable({info_len_ff, crc_len_ff, rom_crc_ff}))
    else $error("header changed by bus reset");

  AST_HEADER_RESET: assert property (@(posedge i_clock)
      $fell(i_srst) |-> info_len_ff == RST_INFO_LENGTH && crc_len_ff == RST_CRC_LENGTH)
    else $error("header lengths wrong after reset");

  AST_CRC_LOAD: assert property (@(posedge i_clock) disable iff (i_srst)
      rom_load_ff && i_id_rom_present |=> rom_crc_ff == $past(i_id_rom_crc))
    else $error("ROM CRC not loaded");

  // Host compare-and-swap registers
  AST_SEL_CAPTURE: assert property (@(posedge i_clock) disable iff (i_srst)
      ctl_wr |=> sel_ff == $past(i_reg_wdata[1:0]))
    else $error("selector not captured");

  AST_SWAP_HOLD: assert property (@(posedge i_clock) disable iff (i_srst)
      !done_ff && !host_evt && i_reg_wr && i_reg_addr == OFS_SWAP_DATA |=> $stable(swap_data_ff))
    else $error("swap data written while busy");

  AST_HOST_DONE: assert property (@(posedge i_clock) disable iff (i_srst)
      host_evt && !ctl_wr |=> done_ff)
    else $error("done flag not set on finish");

  AST_BUS_KEEPS_SWAP: assert property (@(posedge i_clock) disable iff (i_srst)
      bus_evt && !(i_reg_wr && i_reg_addr == OFS_SWAP_DATA) |=> $stable(swap_data_ff))
    else $error("bus operation disturbed host swap data");

endmodule : bmcsr_unit

// File: bench/bmcsr_bus_node.sv
// Remote serial-bus node model issuing quadlet reads and compare-swap locks
module bmcsr_bus_node
  import bmcsr_pkg::*;
(
  // Clock
  input  wire logic        i_clock,
  // Answer from the device
  input  wire logic        i_bus_ack,
  input  wire logic        i_bus_err,
  input  wire logic [31:0] i_bus_rdata,
  // Request to the device
  output logic             o_bus_req,
  output logic             o_bus_lock,
  output logic [47:0]      o_bus_addr,
  output logic [31:0]      o_bus_arg,
  output logic [31:0]      o_bus_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_bus_req  = 1'b0;
    o_bus_lock = 1'b0;
    o_bus_addr = 48'h0;
    o_bus_arg  = 32'h0;
    o_bus_data = 32'h0;
  end

  // One request outstanding; qualifiers held until the answer, then scrambled
  task automatic access(input logic lock, input logic [47:0] addr, input logic [31:0] arg,
                        input logic [31:0] data, output logic [31:0] rdata, output logic err, output bit ok);
    ok = 1'b0;
    @(posedge i_clock);
    o_bus_req  <= 1'b1;
    o_bus_lock <= lock;
    o_bus_addr <= addr;
    o_bus_arg  <= arg;
    o_bus_data <= data;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge i_clock);
      o_bus_req <= 1'b0;
      #1;
      if (i_bus_ack === 1'b1) begin
        ok    = 1'b1;
        rdata = i_bus_rdata;
        err   = i_bus_err;
      end
    end
    @(posedge i_clock);
    o_bus_lock <= ~lock;
    o_bus_addr <= ~addr;
    o_bus_arg  <= ~arg;
    o_bus_data <= ~data;
  endtask : access
endmodule : bmcsr_bus_node

// File: bench/tb_top.sv
// Self-checking testbench of the bus management CSR unit
module tb_top
  import bmcsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ROM_CRC = 16'hA5C3;
  localparam logic [31:0] HDR_RST = {RST_INFO_LENGTH, RST_CRC_LENGTH, ROM_CRC};
  logic        i_clock, i_srst, bus_reset, wr_s, rd_s, bus_req, bus_lock, bus_ack, bus_err, irq;
  logic [7:0]  reg_addr;
  logic [31:0] wdata, rdata, bus_arg, bus_data, bus_rdata;
  logic [47:0] bus_addr;
  int          n_mismatch = 0;
  int          check_count = 0;
  logic [31:0] rst_val [4] = '{RST_BUS_MANAGER, RST_BANDWIDTH, RST_CHANNELS, RST_CHANNELS};

  bmcsr_unit i_dut (
    .i_clock(i_clock), .i_srst(i_srst), .i_bus_reset(bus_reset), .i_id_rom_present(1'b1),
    .i_id_rom_crc(ROM_CRC), .i_reg_addr(reg_addr), .i_reg_wdata(wdata), .i_reg_wr(wr_s),
    .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_bus_req(bus_req), .i_bus_lock(bus_lock),
    .i_bus_addr(bus_addr), .i_bus_arg(bus_arg), .i_bus_data(bus_data), .o_bus_ack(bus_ack),
    .o_bus_err(bus_err), .o_bus_rdata(bus_rdata), .o_irq(irq));
  bmcsr_bus_node i_node (
    .i_clock(i_clock), .i_bus_ack(bus_ack), .i_bus_err(bus_err), .i_bus_rdata(bus_rdata),
    .o_bus_req(bus_req), .o_bus_lock(bus_lock), .o_bus_addr(bus_addr), .o_bus_arg(bus_arg),
    .o_bus_data(bus_data));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    wr_s     <= 1'b1;
    reg_addr <= a;
    wdata    <= d;
    @(posedge i_clock);
    wr_s     <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clock);
    rd_s     <= 1'b1;
    reg_addr <= a;
    @(posedge i_clock);
    rd_s     <= 1'b0;
    #1 v = rdata;
  endtask : reg_read
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    reg_read(a, v);
    check(name, v, exp);
  endtask : rd_chk
  task automatic wait_done;
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 8 && v[POS_CAS_DONE] !== 1'b1; i++) reg_read(OFS_CAS_CONTROL, v);
    check("done", {31'h0, v[POS_CAS_DONE]}, 32'h1);
    if (v[POS_CAS_DONE] !== 1'b1) wrap_up();
  endtask : wait_done
  task automatic host_cas(input logic [31:0] swap, input logic [31:0] cmp, input logic [1:0] sel);
    reg_write(OFS_SWAP_DATA, swap);
    reg_write(OFS_COMPARE, cmp);
    reg_write(OFS_CAS_CONTROL, {30'h0, sel});
    wait_done();
  endtask : host_cas
  task automatic bus_op(input logic lk, input logic [47:0] a, input logic [31:0] arg, input logic [31:0] d,
                        input logic [31:0] exp, input logic exp_err);
    logic [31:0] v;
    logic        e;
    bit          ok;
    i_node.access(lk, a, arg, d, v, e, ok);
    if (!ok) begin
      n_mismatch++;
      wrap_up();
    end
    check("bus_err", {31'h0, e}, {31'h0, exp_err});
    if (!exp_err) check("bus_rdata", v, exp);
  endtask : bus_op
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge i_clock);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask : irq_chk

  task automatic t_reset;
    for (int s = 0; s < 4; s++) rd_chk("resource", OFS_RESOURCE0 + 8'(4 * s), rst_val[s]);
    rd_chk("header", OFS_ROM_HEADER, HDR_RST);
    rd_chk("bus_ident", OFS_BUS_IDENT, BUS_IDENT_VALUE);
    rd_chk("irq_status", OFS_IRQ_STATUS, 32'h0);
    wait_done();
    $display("test reset done");
  endtask : t_reset
  task automatic t_host;
    for (int s = 0; s < 4; s++) begin
      host_cas(32'h11 + s, rst_val[s], 2'(s));
      rd_chk("resource", OFS_RESOURCE0 + 8'(4 * s), 32'h11 + s);
      rd_chk("old_value", OFS_SWAP_DATA, rst_val[s]);
    end
    irq_chk(1'b0);
    reg_write(OFS_IRQ_MASK, 32'h1);
    irq_chk(1'b1);
    host_cas(32'h2A, 32'h3F, SEL_BUS_MANAGER);
    rd_chk("resource", OFS_RESOURCE0, 32'h11);
    rd_chk("old_value", OFS_SWAP_DATA, 32'h11);
    reg_write(OFS_IRQ_STATUS, 32'h1);
    irq_chk(1'b0);
    $display("test host done");
  endtask : t_host
  task automatic t_bus;
    logic [31:0] v;
    bus_op(1'b1, CSR_RESOURCE_BASE, 32'h11, 32'h07, 32'h11, 1'b0);
    rd_chk("resource", OFS_RESOURCE0, 32'h07);
    bus_op(1'b1, CSR_RESOURCE_BASE + 48'h4, 32'h0, 32'h5, 32'h12, 1'b0);
    bus_op(1'b0, CSR_RESOURCE_BASE + 48'h4, 32'h0, 32'h0, 32'h12, 1'b0);
    bus_op(1'b0, CSR_RESOURCE_LAST, 32'h0, 32'h0, 32'h14, 1'b0);
    bus_op(1'b0, CSR_ROM_HEADER, 32'h0, 32'h0, HDR_RST, 1'b0);
    bus_op(1'b0, CSR_BUS_INFO0, 32'h0, 32'h0, BUS_IDENT_VALUE, 1'b0);
    bus_op(1'b1, CSR_ROM_HEADER, 32'h0, 32'h0, 32'h0, 1'b1);
    bus_op(1'b0, 48'hFFFF_F000_0300, 32'h0, 32'h0, 32'h0, 1'b1);
    reg_read(OFS_IRQ_STATUS, v);
    check("bus_event", {31'h0, v[POS_IRQ_BUS]}, 32'h1);
    reg_write(OFS_IRQ_MASK, 32'h2);
    irq_chk(1'b1);
    reg_write(OFS_IRQ_STATUS, 32'h3);
    irq_chk(1'b0);
    reg_write(OFS_RESOURCE0 + 8'h08, 32'h0);
    reg_write(OFS_BUS_IDENT, 32'h0);
    rd_chk("resource", OFS_RESOURCE0 + 8'h08, 32'h13);
    rd_chk("bus_ident", OFS_BUS_IDENT, BUS_IDENT_VALUE);
    $display("test bus done");
  endtask : t_bus
  task automatic t_race;
    reg_write(OFS_SWAP_DATA, 32'h200);
    reg_write(OFS_COMPARE, 32'h12);
    fork
      reg_write(OFS_CAS_CONTROL, 32'h1);
      bus_op(1'b1, CSR_RESOURCE_BASE + 48'h4, 32'h12, 32'h100, 32'h12, 1'b0);
    join
    wait_done();
    rd_chk("resource", OFS_RESOURCE0 + 8'h04, 32'h100);
    rd_chk("old_value", OFS_SWAP_DATA, 32'h100);
    $display("test race done");
  endtask : t_race
  task automatic t_bus_reset;
    reg_write(OFS_ROM_HEADER, 32'h0808_1234);
    @(posedge i_clock);
    bus_reset <= 1'b1;
    @(posedge i_clock);
    bus_reset <= 1'b0;
    for (int s = 0; s < 4; s++) rd_chk("resource", OFS_RESOURCE0 + 8'(4 * s), rst_val[s]);
    rd_chk("header", OFS_ROM_HEADER, 32'h0808_1234);
    $display("test bus reset done");
  endtask : t_bus_reset

  initial begin
    i_srst    = 1'b1;
    bus_reset = 1'b0;
    wr_s      = 1'b0;
    rd_s      = 1'b0;
    reg_addr  = 8'h00;
    wdata     = 32'h0;
    repeat (5) @(posedge i_clock);
    i_srst <= 1'b0;
    t_reset();
    t_host();
    t_bus();
    t_race();
    t_bus_reset();
    wrap_up();
  end
endmodule : tb_top
